// >>> logic/dbd_top.v
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "dbd_map.vh"

// ==========================================================================
// Dual bridge drive control
// ==========================================================================
module dbd_top #(
  parameter DEAD_CYC = `DBD_DEAD_CYC,
  parameter PUMP_HALF = `DBD_PUMP_HALF_CYC
) (
  input wire MCLK_I,
  input wire RST_I,
  input wire EN_A_I,
  input wire LEG1_A_I,
  input wire LEG2_A_I,
  input wire EN_B_I,
  input wire LEG1_B_I,
  input wire LEG2_B_I,
  input wire OC_A_I,
  input wire OC_B_I,
  input wire THERM_HOT_I,
  output wire [1:0] OUT_A_HI_O,
  output wire [1:0] OUT_A_LO_O,
  output wire [1:0] OUT_B_HI_O,
  output wire [1:0] OUT_B_LO_O,
  output wire [1:0] OUT_A_OE_O,
  output wire [1:0] OUT_B_OE_O,
  output wire FAULT_A_O,
  output wire FAULT_A_OE_O,
  output wire FAULT_B_O,
  output wire FAULT_B_OE_O,
  output reg PUMP_O,
  output wire IRQ_O,
  input wire [3:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output wire AVS_WAITREQUEST_O
);
  // ========================================================================
  // Input synchronisation
  // ========================================================================
  wire [8:0] pins;
  wire en_a, l1a, l2a, en_b, l1b, l2b, oc_a, oc_b, hot;

  dbd_sync2 #(.W(9)) u_sync (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .d_i({EN_A_I, LEG1_A_I, LEG2_A_I, EN_B_I, LEG1_B_I, LEG2_B_I,
          OC_A_I, OC_B_I, THERM_HOT_I}),
    .q_o(pins)
  );
  assign {en_a, l1a, l2a, en_b, l1b, l2b, oc_a, oc_b, hot} = pins;

  // ========================================================================
  // Thermal shutdown
  // ========================================================================
  // The sensor's own comparator carries the hysteresis; this flag follows it.
  reg therm_off;
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      therm_off <= 1'b0;
    end else begin
      therm_off <= hot;
    end
  end

  wire run_a = en_a && !therm_off;
  wire run_b = en_b && !therm_off;

  // ========================================================================
  // Legs, two per channel
  // ========================================================================
  wire [1:0] hi_a, lo_a, hi_b, lo_b;

  dbd_leg #(.DEAD_CYC(DEAD_CYC)) u_leg_a1 (
    .clk_i(MCLK_I), .rst_i(RST_I), .en_i(run_a), .leg_i(l1a),
    .hi_on_o(hi_a[0]), .lo_on_o(lo_a[0])
  );
  dbd_leg #(.DEAD_CYC(DEAD_CYC)) u_leg_a2 (
    .clk_i(MCLK_I), .rst_i(RST_I), .en_i(run_a), .leg_i(l2a),
    .hi_on_o(hi_a[1]), .lo_on_o(lo_a[1])
  );
  dbd_leg #(.DEAD_CYC(DEAD_CYC)) u_leg_b1 (
    .clk_i(MCLK_I), .rst_i(RST_I), .en_i(run_b), .leg_i(l1b),
    .hi_on_o(hi_b[0]), .lo_on_o(lo_b[0])
  );
  dbd_leg #(.DEAD_CYC(DEAD_CYC)) u_leg_b2 (
    .clk_i(MCLK_I), .rst_i(RST_I), .en_i(run_b), .leg_i(l2b),
    .hi_on_o(hi_b[1]), .lo_on_o(lo_b[1])
  );

  assign OUT_A_HI_O = hi_a;
  assign OUT_A_LO_O = lo_a;
  assign OUT_B_HI_O = hi_b;
  assign OUT_B_LO_O = lo_b;
  // An output drives only while one of its switches conducts.
  assign OUT_A_OE_O = hi_a | lo_a;
  assign OUT_B_OE_O = hi_b | lo_b;

  // ========================================================================
  // Open-drain fault outputs
  // ========================================================================
  reg flt_a, flt_b;
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      flt_a <= 1'b0;
      flt_b <= 1'b0;
    end else begin
      flt_a <= oc_a;
      flt_b <= oc_b;
    end
  end
  assign FAULT_A_O = 1'b0;
  assign FAULT_A_OE_O = flt_a;
  assign FAULT_B_O = 1'b0;
  assign FAULT_B_OE_O = flt_b;

  // ========================================================================
  // Charge-pump oscillator
  // ========================================================================
  reg [15:0] pump_cnt;
  always @(posedge MCLK_I) begin
    if (RST_I) begin
      pump_cnt <= 16'h0000;
      PUMP_O <= 1'b0;
    end else if (pump_cnt == PUMP_HALF[15:0] - 16'h0001) begin
      pump_cnt <= 16'h0000;
      PUMP_O <= !PUMP_O;
    end else begin
      pump_cnt <= pump_cnt + 16'h0001;
    end
  end

  // ========================================================================
  // Registers and interrupt
  // ========================================================================
  reg [`DBD_STAT_W-1:0] status, mask;
  reg [`DBD_LIMIT_W-1:0] limit_a, limit_b;
  reg oc_a_d, oc_b_d, hot_d;
  reg rd_ack;
  wire wr = AVS_WRITE_I && AVS_BYTEENABLE_I[0];
  wire [`DBD_STAT_W-1:0] events;
  wire [`DBD_STAT_W-1:0] clr;

  assign events = {hot && !hot_d, oc_b && !oc_b_d, oc_a && !oc_a_d};
  assign clr = (wr && AVS_ADDRESS_I == `DBD_REG_STATUS) ?
               AVS_WRITEDATA_I[`DBD_STAT_W-1:0] : {`DBD_STAT_W{1'b0}};
  // Read data is registered, so a read waits one cycle for it to stand.
  assign AVS_WAITREQUEST_O = AVS_READ_I && !rd_ack;
  assign IRQ_O = |(status & mask);

  always @(posedge MCLK_I) begin
    if (RST_I) begin
      status <= {`DBD_STAT_W{1'b0}};
      mask <= `DBD_MASK_RST;
      limit_a <= `DBD_LIMIT_RST;
      limit_b <= `DBD_LIMIT_RST;
      oc_a_d <= 1'b0;
      oc_b_d <= 1'b0;
      hot_d <= 1'b0;
      rd_ack <= 1'b0;
      AVS_READDATA_O <= 32'h00000000;
    end else begin
      rd_ack <= AVS_READ_I && !rd_ack;
      oc_a_d <= oc_a;
      oc_b_d <= oc_b;
      hot_d <= hot;
      // A new event wins over a clear in the same cycle.
      status <= (status & ~clr) | events;
      if (wr && AVS_ADDRESS_I == `DBD_REG_IRQ_MASK) begin
        mask <= AVS_WRITEDATA_I[`DBD_STAT_W-1:0];
      end
      // Limit codes hold the programmed threshold in milliamperes.
      if (AVS_WRITE_I && AVS_ADDRESS_I == `DBD_REG_LIMIT_A) begin
        limit_a <= AVS_WRITEDATA_I[`DBD_LIMIT_W-1:0];
      end
      if (AVS_WRITE_I && AVS_ADDRESS_I == `DBD_REG_LIMIT_B) begin
        limit_b <= AVS_WRITEDATA_I[`DBD_LIMIT_W-1:0];
      end
      AVS_READDATA_O <= 32'h00000000;
      if (AVS_READ_I) begin
        case (AVS_ADDRESS_I)
          `DBD_REG_STATUS: begin
            AVS_READDATA_O <= {21'h000000, hot, oc_b, oc_a, 5'h00, status};
          end
          `DBD_REG_IRQ_MASK: begin
            AVS_READDATA_O <= {29'h00000000, mask};
          end
          `DBD_REG_LIMIT_A: begin
            AVS_READDATA_O <= {16'h0000, limit_a};
          end
          `DBD_REG_LIMIT_B: begin
            AVS_READDATA_O <= {16'h0000, limit_b};
          end
          default: begin
            AVS_READDATA_O <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// >>> logic/dbd_map.vh
`ifndef DBD_MAP_VH
`define DBD_MAP_VH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define DBD_CLK_HZ 100000000
`define DBD_DEAD_NS 1000
`define DBD_DEAD_CYC ((`DBD_DEAD_NS * (`DBD_CLK_HZ / 1000000) + 999) / 1000)
`define DBD_PUMP_HZ 600000
`define DBD_PUMP_HALF_CYC (`DBD_CLK_HZ / (2 * `DBD_PUMP_HZ))

// ==========================================================================
// Register offsets
// ==========================================================================
`define DBD_REG_STATUS 4'h0
`define DBD_REG_IRQ_MASK 4'h4
`define DBD_REG_LIMIT_A 4'h8
`define DBD_REG_LIMIT_B 4'hc

// ==========================================================================
// Status and mask bit positions
// ==========================================================================
`define DBD_BIT_OC_A 0
`define DBD_BIT_OC_B 1
`define DBD_BIT_THERM 2
`define DBD_STAT_W 3
`define DBD_LIVE_OC_A 8
`define DBD_LIVE_OC_B 9
`define DBD_LIVE_THERM 10

// ==========================================================================
// Reset values
// ==========================================================================
`define DBD_MASK_RST 3'h0
`define DBD_LIMIT_W 16
`define DBD_LIMIT_RST 16'h0000

`endif

// >>> logic/dbd_sync2.v
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Two-stage synchroniser
// ==========================================================================
module dbd_sync2 #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

`default_nettype wire

// >>> logic/dbd_leg.v
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// One half-bridge leg with dead time
// ==========================================================================
module dbd_leg #(
  parameter DEAD_CYC = 100
) (
  input wire clk_i,
  input wire rst_i,
  input wire en_i,
  input wire leg_i,
  output reg hi_on_o,
  output reg lo_on_o
);
  // Counter sized generously; dead time stays far below 65536 cycles.
  reg [15:0] cnt;
  reg target;

  always @(posedge clk_i) begin
    if (rst_i) begin
      hi_on_o <= 1'b0;
      lo_on_o <= 1'b0;
      cnt <= 16'h0000;
      target <= 1'b0;
    end else if (!en_i) begin
      hi_on_o <= 1'b0;
      lo_on_o <= 1'b0;
      // A switch cut by disable still needs its dead time before a quick
      // re-enable may turn on the complementary one.
      if (hi_on_o || lo_on_o) begin
        cnt <= DEAD_CYC[15:0];
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end
      target <= leg_i;
    end else if (leg_i != target) begin
      // Both switches go off first; the new side waits out the dead time.
      target <= leg_i;
      hi_on_o <= 1'b0;
      lo_on_o <= 1'b0;
      cnt <= DEAD_CYC[15:0];
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end else begin
      hi_on_o <= target;
      lo_on_o <= !target;
    end
  end
endmodule

`default_nettype wire

// >>> verif/dbd_props.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checker
module dbd_props #(
  parameter int DEAD_CYC = 100,
  parameter int PUMP_HALF = 83
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic EN_A_I,
  input wire logic OC_A_I,
  input wire logic THERM_HOT_I,
  input wire logic [1:0] OUT_A_HI_O,
  input wire logic [1:0] OUT_A_LO_O,
  input wire logic [1:0] OUT_A_OE_O,
  input wire logic FAULT_A_OE_O,
  input wire logic PUMP_O
);
  localparam int PH1 = PUMP_HALF + 1;
  logic [7:0] lo_off;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  // Saturates so that a long idle stretch never wraps to a short count.
  always_ff @(posedge MCLK_I)
    lo_off <= (RST_I || OUT_A_LO_O[0]) ? 8'h00 : lo_off + 8'(lo_off != 8'hff);
  sequence s_en_low; !EN_A_I [*4]; endsequence
  sequence s_oc(b); (OC_A_I == b) [*4]; endsequence
  sequence s_hot; THERM_HOT_I [*4]; endsequence
  property p_cross; (OUT_A_HI_O & OUT_A_LO_O) == 2'b00; endproperty
  property p_dead; $rose(OUT_A_HI_O[0]) |-> lo_off >= DEAD_CYC; endproperty
  property p_oe; OUT_A_OE_O == (OUT_A_HI_O | OUT_A_LO_O); endproperty
  property p_off; s_en_low |=> OUT_A_OE_O == 2'b00; endproperty
  property p_flt_on; s_oc(1'b1) |=> FAULT_A_OE_O; endproperty
  property p_flt_off; s_oc(1'b0) |=> !FAULT_A_OE_O; endproperty
  property p_hot; s_hot |=> OUT_A_OE_O == 2'b00; endproperty
  property p_pump; 1'b1 |-> ##[1:PH1] PUMP_O != $past(PUMP_O); endproperty
  a_cross: assert property (p_cross) else $error("both switches on");
  a_dead: assert property (p_dead) else $error("dead time short");
  a_oe: assert property (p_oe) else $error("drive enable wrong");
  a_off: assert property (p_off) else $error("disabled leg drives");
  a_flt_on: assert property (p_flt_on) else $error("fault not shown");
  a_flt_off: assert property (p_flt_off) else $error("fault stuck");
  a_hot: assert property (p_hot) else $error("hot leg drives");
  a_pump: assert property (p_pump) else $error("pump stalled");
endmodule
bind dbd_top dbd_props #(.DEAD_CYC(DEAD_CYC), .PUMP_HALF(PUMP_HALF))
  dbd_props_i (.*);
`default_nettype wire

// >>> verif/dbd_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Host controller model
module dbd_host #(
  parameter int HOLD = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic want_i,
  input wire logic line_i,
  output logic en_o
);
  logic [7:0] hold;
  assign en_o = want_i && hold == 8'h00;
  // A low node while the host drives high can only be the fault output, so
  // the host backs off for the disable time instead of fighting it.
  always @(posedge clk_i) begin
    if (rst_i)
      hold <= 8'h00;
    else if (en_o && !line_i)
      hold <= 8'(HOLD);
    else if (hold != 8'h00)
      hold <= hold - 8'h01;
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench
module tb_top;
  localparam int DC = 4;
  logic clk = 0, rst = 1, want = 0, en_b = 0, oc_a = 0, hot = 0;
  logic rd = 0, wr = 0;
  logic [1:0] lg_a = 0, lg_b = 0;
  logic [3:0] adr = 0;
  logic [31:0] wd = 0, rdat;
  wire [1:0] a_hi, a_lo, b_hi, a_oe, b_oe;
  wire f_a, f_a_oe, pump, irq, wreq, hen;
  wire [31:0] rdata;
  int fails = 0, checks_done = 0, cyc = 0;
  // The enable node has a pull-up; the fault output can only pull it low.
  wire en_a = hen & ~f_a_oe;
  dbd_top #(.DEAD_CYC(DC), .PUMP_HALF(2)) dbd_top_i (
    .MCLK_I(clk), .RST_I(rst), .EN_A_I(en_a), .LEG1_A_I(lg_a[0]),
    .LEG2_A_I(lg_a[1]), .EN_B_I(en_b), .LEG1_B_I(lg_b[0]),
    .LEG2_B_I(lg_b[1]), .OC_A_I(oc_a), .OC_B_I(1'b0), .THERM_HOT_I(hot),
    .OUT_A_HI_O(a_hi), .OUT_A_LO_O(a_lo), .OUT_B_HI_O(b_hi),
    .OUT_B_LO_O(), .OUT_A_OE_O(a_oe), .OUT_B_OE_O(b_oe),
    .FAULT_A_O(f_a), .FAULT_A_OE_O(f_a_oe), .FAULT_B_O(), .FAULT_B_OE_O(),
    .PUMP_O(pump), .IRQ_O(irq), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq));
  dbd_host dbd_host_i (.clk_i(clk), .rst_i(rst), .want_i(want),
    .line_i(en_a), .en_o(hen));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Read data is taken at the edge where waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {adr, wr, rd, wd} <= {a, w, !w, d};
    do @(posedge clk); while (wreq !== 1'b0);
    rdat = rdata;
    {wr, rd} <= 2'b00;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 16; i += 4) begin
      bus(0, 4'(i), 0);
      chk("reset reg", 0, rdat);
    end
    bus(1, 4'h8, 32'h1144);
    bus(1, 4'hc, 32'h15e0);
    bus(0, 4'h8, 0);
    chk("limit a", 32'h1144, rdat);
    bus(0, 4'hc, 0);
    chk("limit b", 32'h15e0, rdat);
  endtask
  task automatic t_truth;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {want, en_b, lg_a, lg_b} <= {2'b11, 2'(i), 2'(~i)};
      at(DC + 10);
      chk("hi a", i & 3, a_hi);
      chk("lo a", ~i & 3, a_lo);
      chk("hi b", ~i & 3, b_hi);
    end
    @(posedge clk);
    en_b <= 0;
    at(8);
    chk("oe ab", 4'hc, {a_oe, b_oe});
  endtask
  task automatic t_dead;
    int n = 0;
    @(posedge clk);
    lg_a <= 2'b00;
    repeat (30) begin
      at(1);
      if (a_hi[0] === 1'b0 && a_lo[0] === 1'b0) n++;
    end
    chk("dead", 1, n >= DC);
    chk("lo a", 3, a_lo);
  endtask
  task automatic t_fault;
    @(posedge clk);
    oc_a <= 1;
    at(8);
    chk("fault", 3'b100, {f_a_oe, f_a, irq});
    chk("oe a", 0, a_oe);
    @(posedge clk);
    oc_a <= 0;
    bus(1, 4'h4, 1);
    at(2);
    chk("irq oe", 3'b100, {irq, a_oe});
    bus(0, 4'h0, 0);
    chk("status", 1, rdat & 7);
    bus(1, 4'h0, 1);
    at(2);
    chk("irq", 0, irq);
    at(60);
    chk("oe a", 3, a_oe);
    @(posedge clk);
    hot <= 1;
    at(4);
    bus(0, 4'h0, 0);
    chk("hot", 32'h404, {rdat & 32'h707} | a_oe);
    @(posedge clk);
    hot <= 0;
    at(20);
    chk("oe a", 3, a_oe);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    t_regs();
    t_truth();
    t_dead();
    t_fault();
    test_done();
  end
endmodule
`default_nettype wire
